/* File: binary_pkg.sv */
// shared constants and types for the edge-triggered binary family
// assumes a single 100 MHz system clock on both ends
package binary_pkg;

  // which member of the family the element behaves as
  typedef enum logic [2:0] {
    var_ms,        // master-slave j-k, falling edge
    var_gated_jk,  // single gated j-k, rising edge
    var_dual_d,    // d element, rising edge
    var_ac_sep,    // capacitively coupled j-k, own clock, clear only
    var_ac_com,    // capacitively coupled j-k, common clock, set and clear
    var_hs_jk,     // high-speed gated j-k, falling edge, master locked at rise
    var_sc,        // stored-charge j-k, falling edge
    var_rst        // rs/t element, falling edge, active-low clocked inputs
  } variant_t;

  localparam int unsigned CLK_PERIOD_NS  = 10;
  // least width of each binary clock phase
  localparam int unsigned BCLK_HIGH_NS   = 20;
  localparam int unsigned BCLK_LOW_NS    = 20;
  // least time a direct input is held low
  localparam int unsigned DIRECT_NS      = 20;
  localparam int unsigned BCLK_HIGH_CYC  = (BCLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BCLK_LOW_CYC   = (BCLK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIRECT_CYC     = (DIRECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 4;
  localparam logic        Q_RST          = 1'b0;

endpackage

/* File: binary_if.sv */
// pins between the binary element and the logic that drives it
// assumes both ends share the system clock
`timescale 1ns/100ps
interface binary_if;
  import binary_pkg::*;
  variant_t variant;
  logic     bclk;
  logic     j;
  logic     k;
  logic     jbar;
  logic     kbar;
  logic     d;
  logic     cset_n;
  logic     cclr_n;
  logic     dset_n;
  logic     dclr_n;
  logic     q;
  logic     q_n;

  modport dev (
    input  variant, bclk, j, k, jbar, kbar, d, cset_n, cclr_n, dset_n, dclr_n,
    output q, q_n
  );
  modport drv (
    output variant, bclk, j, k, jbar, kbar, d, cset_n, cclr_n, dset_n, dclr_n,
    input  q, q_n
  );
endinterface

/* File: binary_dev.sv */
// the binary element: one storage element whose behaviour follows the selected variant
// assumes the driving logic runs on the same clock, so pins are not synchronised
//
// Overview of operation
// - master-slave outputs change only on falling edge
// - master follows j and k while clock high
// - master copied to slave on falling edge
// - driver holds j, k steady while clock high
// - gated j-k and d update on rising edge
// - rising-edge types ignore inputs once clock high
// - capacitively coupled j-k update on falling edge
// - driver settles j, k before rise, holds to fall
// - high-speed j-k falls, master locked after rise
// - stored-charge falls; driver holds j, k rise-to-fall
// - driver holds clocked set/clear steady while high
// - driver ties unused inverted j, k low
// - rs/t direct inputs act on logic zero
// - master-slave direct inputs act at any clock level
// - gated j-k direct set/clear force true output
// - driver asserts gated j-k direct only clock low
// - direct during clock high may drop both outputs
// - afterwards gated j-k reverts to earlier state
// - coupled j-k clear any level; set common only
// - d and high-speed direct inputs force at once
// - stored-charge direct inputs act at any level
`timescale 1ns/100ps
module binary_dev (
  // system
  input  wire logic clock,
  input  wire logic rst,
  // pins
  binary_if.dev     pins
);
  import binary_pkg::*;

  logic bclk_d_r;
  logic master_r;
  logic master_nxt;
  logic state_r;
  logic state_nxt;
  logic q_r;
  logic qn_r;
  logic q_nxt;
  logic qn_nxt;
  logic rise;
  logic fall;
  logic j_eff;
  logic k_eff;
  logic set_hit;
  logic clr_hit;
  logic glitch;

  function automatic logic jk_next(input logic cur, input logic jj, input logic kk);
    unique case ({jj, kk})
      2'b00: jk_next = cur;
      2'b10: jk_next = 1'b1;
      2'b01: jk_next = 1'b0;
      2'b11: jk_next = ~cur;
    endcase
  endfunction

  // rs/t: low set sets, low clear clears, both low toggles
  function automatic logic rs_next(input logic cur, input logic s_n, input logic c_n);
    unique case ({s_n, c_n})
      2'b11: rs_next = cur;
      2'b01: rs_next = 1'b1;
      2'b10: rs_next = 1'b0;
      2'b00: rs_next = ~cur;
    endcase
  endfunction

  assign rise = pins.bclk & ~bclk_d_r;
  assign fall = ~pins.bclk & bclk_d_r;

  // a high inverted input blocks the gating
  always_comb begin
    if (pins.variant == var_gated_jk || pins.variant == var_hs_jk) begin
      j_eff = pins.j & ~pins.jbar;
      k_eff = pins.k & ~pins.kbar;
    end else begin
      j_eff = pins.j;
      k_eff = pins.k;
    end
  end

  // own-clock coupled type has no direct set
  assign set_hit = ~pins.dset_n & (pins.variant != var_ac_sep);
  assign clr_hit = ~pins.dclr_n;

  // direct input on gated j-k while clock high
  assign glitch = (pins.variant == var_gated_jk) & pins.bclk & (set_hit | clr_hit);

  always_comb begin
    master_nxt = master_r;
    state_nxt  = state_r;
    unique case (pins.variant)
      var_ms: begin
        if (pins.bclk) begin
          master_nxt = jk_next(state_r, j_eff, k_eff);
        end
        if (fall) begin
          state_nxt = master_r;
        end
      end
      var_hs_jk: begin
        // master samples once at rise, then locked
        if (rise) begin
          master_nxt = jk_next(state_r, j_eff, k_eff);
        end
        if (fall) begin
          state_nxt = master_r;
        end
      end
      var_gated_jk: begin
        // one update per pulse at the rise
        if (rise) begin
          state_nxt = jk_next(state_r, j_eff, k_eff);
        end
      end
      var_dual_d: begin
        if (rise) begin
          state_nxt = pins.d;
        end
      end
      var_ac_sep, var_ac_com, var_sc: begin
        if (fall) begin
          state_nxt = jk_next(state_r, j_eff, k_eff);
        end
      end
      var_rst: begin
        if (fall) begin
          state_nxt = rs_next(state_r, pins.cset_n, pins.cclr_n);
        end
      end
    endcase
    // state held so it returns once released
    if (glitch) begin
      master_nxt = master_r;
      state_nxt  = state_r;
    // otherwise direct inputs win at any level, clear first
    end else if (clr_hit) begin
      master_nxt = 1'b0;
      state_nxt  = 1'b0;
    end else if (set_hit) begin
      master_nxt = 1'b1;
      state_nxt  = 1'b1;
    end
  end

  // complement tracks true output except in glitch
  always_comb begin
    if (glitch) begin
      q_nxt  = 1'b0;
      qn_nxt = 1'b0;
    end else begin
      q_nxt  = state_nxt;
      qn_nxt = ~state_nxt;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bclk_d_r <= 1'b0;
    end else begin
      bclk_d_r <= pins.bclk;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      master_r <= Q_RST;
      state_r  <= Q_RST;
    end else begin
      master_r <= master_nxt;
      state_r  <= state_nxt;
    end
  end

  // outputs registered, so a forced value shows one clock later
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_r  <= Q_RST;
      qn_r <= ~Q_RST;
    end else begin
      q_r  <= q_nxt;
      qn_r <= qn_nxt;
    end
  end

  assign pins.q   = q_r;
  assign pins.q_n = qn_r;

endmodule

/* File: binary_drv.sv */
// driving logic for the binary element: makes the binary clock and sequences its inputs
// assumes one request at a time from the user side, same clock as the element
`timescale 1ns/100ps
module binary_drv (
  // system
  input  wire logic                 clock,
  input  wire logic                 rst,
  // user request
  input  wire logic                 req,
  input  wire logic                 direct,
  input  wire binary_pkg::variant_t variant,
  input  wire logic                 j,
  input  wire logic                 k,
  input  wire logic                 d,
  input  wire logic                 cset_n,
  input  wire logic                 cclr_n,
  input  wire logic                 dset_n,
  input  wire logic                 dclr_n,
  // user answer
  output logic                      busy,
  output logic                      done,
  output logic                      q_seen,
  // pins
  binary_if.drv                     pins
);
  import binary_pkg::*;

  typedef enum logic [2:0] {st_idle, st_setup, st_high, st_hold, st_direct} drv_state_t;

  drv_state_t          st_r;
  logic [CNT_W-1:0]    cnt_r;
  variant_t            var_r;
  logic                bclk_r;
  logic                j_r;
  logic                k_r;
  logic                d_r;
  logic                cset_r;
  logic                cclr_r;
  logic                dset_r;
  logic                dclr_r;
  logic                busy_r;
  logic                done_r;
  logic                qs_r;

  localparam logic [CNT_W-1:0] HIGH_N   = CNT_W'(BCLK_HIGH_CYC - 1);
  localparam logic [CNT_W-1:0] LOW_N    = CNT_W'(BCLK_LOW_CYC - 1);
  localparam logic [CNT_W-1:0] DIRECT_N = CNT_W'(DIRECT_CYC - 1);

  // sequencer: inputs settle with clock low, stay until after the fall
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r   <= st_idle;
      cnt_r  <= '0;
      bclk_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (st_r)
        st_idle: begin
          if (req) begin
            cnt_r <= direct ? DIRECT_N : LOW_N;
            st_r  <= direct ? st_direct : st_setup;
          end
        end
        st_setup: begin
          if (cnt_r == '0) begin
            bclk_r <= 1'b1;
            cnt_r  <= HIGH_N;
            st_r   <= st_high;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        st_high: begin
          if (cnt_r == '0) begin
            bclk_r <= 1'b0;
            cnt_r  <= LOW_N;
            st_r   <= st_hold;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        st_hold: begin
          if (cnt_r == '0) begin
            done_r <= 1'b1;
            st_r   <= st_idle;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        // direct pulses only while the binary clock is low
        st_direct: begin
          if (cnt_r == '0) begin
            done_r <= 1'b1;
            st_r   <= st_idle;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  // input pins: captured at the request, direct inputs released when the direct pulse ends
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      var_r  <= var_ms;
      j_r    <= 1'b0;
      k_r    <= 1'b0;
      d_r    <= 1'b0;
      cset_r <= 1'b1;
      cclr_r <= 1'b1;
      dset_r <= 1'b1;
      dclr_r <= 1'b1;
    end else if (st_r == st_idle && req) begin
      var_r  <= variant;
      j_r    <= direct ? 1'b0 : j;
      k_r    <= direct ? 1'b0 : k;
      d_r    <= d;
      cset_r <= direct ? 1'b1 : cset_n;
      cclr_r <= direct ? 1'b1 : cclr_n;
      dset_r <= direct ? dset_n : 1'b1;
      dclr_r <= direct ? dclr_n : 1'b1;
    end else if (st_r == st_direct && cnt_r == '0) begin
      dset_r <= 1'b1;
      dclr_r <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      qs_r   <= Q_RST;
    end else begin
      busy_r <= (st_r == st_idle) ? req : !(done_r == 1'b0 && st_r == st_idle);
      qs_r   <= pins.q;
    end
  end

  assign pins.variant = var_r;
  assign pins.bclk    = bclk_r;
  assign pins.j       = j_r;
  assign pins.k       = k_r;
  // unused inverted inputs held at zero
  assign pins.jbar    = 1'b0;
  assign pins.kbar    = 1'b0;
  assign pins.d       = d_r;
  assign pins.cset_n  = cset_r;
  assign pins.cclr_n  = cclr_r;
  assign pins.dset_n  = dset_r;
  assign pins.dclr_n  = dclr_r;
  assign busy         = busy_r;
  assign done         = done_r;
  assign q_seen       = qs_r;

endmodule

/* File: binary_checker.sv */
// assertions on the pins between the binary element and its driving logic
// assumes one clock for both ends and an active-high reset
`timescale 1ns/100ps
module binary_checker (
  // system
  input logic                 clock,
  input logic                 rst,
  // pins
  input binary_pkg::variant_t variant,
  input logic                 bclk,
  input logic                 j,
  input logic                 k,
  input logic                 jbar,
  input logic                 kbar,
  input logic                 d,
  input logic                 cset_n,
  input logic                 cclr_n,
  input logic                 dset_n,
  input logic                 dclr_n,
  input logic                 q,
  input logic                 q_n
);
  import binary_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence fall_seen;
    dset_n && dclr_n && $fell(bclk);
  endsequence
  sequence rise_seen;
    dset_n && dclr_n && $rose(bclk);
  endsequence

  a_jk_fall: assert property (
    fall_seen ##0 (variant inside {var_ms, var_ac_sep, var_ac_com, var_hs_jk, var_sc})
    |=> q == (($past(j) && !$past(q)) || (!$past(k) && $past(q))))
    else $error("falling-edge jk update wrong");
  a_jk_rise: assert property (
    rise_seen ##0 (variant == var_gated_jk)
    |=> q == (($past(j) && !$past(q)) || (!$past(k) && $past(q))))
    else $error("rising-edge jk update wrong");
  a_d_rise: assert property (
    rise_seen ##0 (variant == var_dual_d) |=> q == $past(d))
    else $error("d element did not store d");
  a_rs_fall: assert property (
    fall_seen ##0 (variant == var_rst)
    |=> q == ((!$past(cset_n) && !$past(q)) || ($past(cclr_n) && $past(q))))
    else $error("rs/t update wrong");
  a_fall_only: assert property (
    $changed(q) && $past(dset_n) && $past(dclr_n)
    && !(variant inside {var_gated_jk, var_dual_d}) |-> $past(bclk, 2) && !$past(bclk))
    else $error("output moved without a falling edge");
  a_rise_only: assert property (
    $changed(q) && $past(dset_n) && $past(dclr_n)
    && (variant inside {var_gated_jk, var_dual_d}) |-> $past(bclk) && !$past(bclk, 2))
    else $error("output moved without a rising edge");
  a_direct_clr: assert property (
    !dclr_n |=> !q)
    else $error("direct clear ignored");
  a_direct_set: assert property (
    !dset_n && dclr_n && variant != var_ac_sep && !(variant == var_gated_jk && bclk) |=> q)
    else $error("direct set ignored");
  a_out_compl: assert property (
    dset_n && dclr_n && $past(dset_n) && $past(dclr_n) |-> q_n == !q)
    else $error("outputs not complementary");
  a_drv_hold: assert property (
    bclk && $past(bclk) |-> $stable(j) && $stable(k) && $stable(cset_n) && $stable(cclr_n))
    else $error("inputs moved while clock high");
  a_tie_low: assert property (
    !jbar && !kbar)
    else $error("inverted gating inputs not low");
  a_direct_low: assert property (
    (variant == var_gated_jk) && (!dset_n || !dclr_n) |-> !bclk)
    else $error("direct input driven while clock high");
endmodule

/* File: tb.sv */
// self-checking bench: driver and element joined by the pin interface
// assumes nothing beyond the design files; ends with one verdict line
`timescale 1ns/100ps
module tb;
  import binary_pkg::*;
  logic     clock, rst, req, direct, j, k, d, cset_n, cclr_n, dset_n, dclr_n;
  logic     busy, done, q_seen;
  variant_t variant;
  int       n_mismatch, num_checks, cycles;

  binary_if bif();
  binary_dev binary_dev_inst (.clock(clock), .rst(rst), .pins(bif));
  binary_drv binary_drv_inst (.clock(clock), .rst(rst), .req(req), .direct(direct),
    .variant(variant), .j(j), .k(k), .d(d), .cset_n(cset_n), .cclr_n(cclr_n),
    .dset_n(dset_n), .dclr_n(dclr_n), .busy(busy), .done(done), .q_seen(q_seen), .pins(bif));
  binary_checker binary_checker_inst (.clock(clock), .rst(rst), .variant(bif.variant),
    .bclk(bif.bclk), .j(bif.j), .k(bif.k), .jbar(bif.jbar), .kbar(bif.kbar), .d(bif.d),
    .cset_n(bif.cset_n), .cclr_n(bif.cclr_n), .dset_n(bif.dset_n), .dclr_n(bif.dclr_n),
    .q(bif.q), .q_n(bif.q_n));

  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // whole run needs under 1000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // b packs j, k, d, cset_n, cclr_n, dset_n, dclr_n
  task automatic op(input logic dir, input variant_t v, input logic [6:0] b, input logic exp);
    int i;
    req <= 1'b1;
    direct <= dir;
    variant <= v;
    {j, k, d, cset_n, cclr_n, dset_n, dclr_n} <= b;
    @(posedge clock);
    req <= 1'b0;
    check({1'b0, busy}, 2'b00);
    for (i = 0; i < 20 && done !== 1'b1; i++) @(posedge clock);
    check({done, busy}, 2'b11);
    check({bif.q, bif.q_n}, {exp, ~exp});
    if (!dir) check({1'b0, q_seen}, {1'b0, exp});
  endtask

  task automatic t_jk();
    variant_t vs[6] = '{var_ms, var_gated_jk, var_ac_sep, var_ac_com, var_hs_jk, var_sc};
    foreach (vs[n]) begin
      op(1'b1, vs[n], 7'h0e, 1'b0);
      op(1'b0, vs[n], 7'h4f, 1'b1);
      op(1'b0, vs[n], 7'h0f, 1'b1);
      op(1'b0, vs[n], 7'h6f, 1'b0);
      op(1'b0, vs[n], 7'h6f, 1'b1);
      op(1'b0, vs[n], 7'h2f, 1'b0);
    end
    $display("test jk ended");
  endtask

  task automatic t_d();
    op(1'b1, var_dual_d, 7'h0e, 1'b0);
    op(1'b0, var_dual_d, 7'h1f, 1'b1);
    op(1'b0, var_dual_d, 7'h0f, 1'b0);
    op(1'b0, var_dual_d, 7'h1f, 1'b1);
    $display("test d ended");
  endtask

  task automatic t_rs();
    op(1'b1, var_rst, 7'h0e, 1'b0);
    op(1'b0, var_rst, 7'h07, 1'b1);
    op(1'b0, var_rst, 7'h0f, 1'b1);
    op(1'b0, var_rst, 7'h0b, 1'b0);
    op(1'b0, var_rst, 7'h03, 1'b1);
    op(1'b0, var_rst, 7'h03, 1'b0);
    $display("test rs ended");
  endtask

  // clear wins when both direct inputs are low
  task automatic t_direct();
    variant_t v;
    for (int n = 0; n < 8; n++) begin
      v = variant_t'(n);
      op(1'b1, v, 7'h0e, 1'b0);
      op(1'b1, v, 7'h0d, v != var_ac_sep);
      op(1'b1, v, 7'h0c, 1'b0);
    end
    $display("test direct ended");
  endtask

  // mid-run reset must drop a stored one
  task automatic t_reset();
    op(1'b1, var_ms, 7'h0d, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check({bif.q, bif.q_n}, 2'b01);
    check({busy, q_seen}, 2'b00);
    $display("test reset ended");
  endtask

  initial begin
    rst = 1'b1;
    req = 1'b0;
    direct = 1'b0;
    variant = var_ms;
    {j, k, d, cset_n, cclr_n, dset_n, dclr_n} = 7'h0f;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check({bif.q, bif.q_n}, 2'b01);
    t_jk();
    t_d();
    t_rs();
    t_direct();
    t_reset();
    complete_run();
  end
endmodule
